// >>> watchdog_defines.svh
// Behaviour
// (R1) Overflow in interrupt mode sets flag bit seven.
// (R2) Interrupt request needs flag, enable, global enable.
// (R3) Flag clears on interrupt taken or write one.
// (R4) Enable bits choose stop/interrupt/reset/both mode.
// (R5) Period select is bit five plus bits two-zero.
// (R6) Codes 0-9 give 2K doubling to 1024K cycles.
// (R7) Overflow time is cycle count of chosen clock.
// (R8) Clearing enable ignored unless unlock bit set.
// (R9) Unlock bit self-clears four cycles after set.
// (R10) Software writes unlock+enable, then clears enable quickly.
// (R11) Reset-mode overflow sets watchdog reset flag.
// (R12) Watchdog reset flag forces enable bit high.
// (R13) Software avoids changing period while counting.
// (R14) Power-on flag set at power-on, write zero clears.
// (R15) Other reset flags set by source, cleared by writes.
// (R16) Bit five shows wake from power-off sleep.
// (R17) Debug-disable bit turns off debug port.
// (R18) Debug-disable needs two writes within four cycles.
// (R19) All resets start at vector address zero.
// (R20) Counter clock is slow RC or fast RC/16.
// (R21) Restart instruction clears the counter.
// (R22) Reset mode emits one-cycle reset pulse on overflow.
// (R23) Interrupt-then-reset becomes reset mode after return.
// (R24) Interrupt-mode overflow wraps counter and continues.
`ifndef WATCHDOG_DEFINES_SVH
`define WATCHDOG_DEFINES_SVH
`define OFS_RESET_CAUSE 32'h0000_0054
`define OFS_WDOG_CTRL 32'h0000_0060
`define BIT_IRQ_FLAG 7
`define BIT_IRQ_EN 6
`define BIT_PER_MSB 5
`define BIT_UNLOCK 4
`define BIT_EN 3
`define BIT_POR 0
`define BIT_PIN 1
`define BIT_LVD 2
`define BIT_DOGRST 3
`define BIT_DBG 4
`define BIT_PWROFF 5
`define BIT_DBG_DIS 7
`define UNLOCK_CYCLES 3'h4
`define RESET_VECTOR 16'h0000
`define PERIOD_BASE_LOG2 5'h0B
`define PERIOD_MAX_CODE 4'h9
`define FAST_DIV 5'h10
`endif

// >>> watchdog_pkg.sv
`default_nettype none
package watchdog_pkg;
  typedef enum logic [1:0] {
    mode_stop = 2'b00,
    mode_irq = 2'b01,
    mode_reset = 2'b10,
    mode_irq_reset = 2'b11
  } dog_mode_t;
endpackage
`default_nettype wire

// >>> watchdog_and_reset_status.sv
`include "watchdog_defines.svh"
`default_nettype none
module watchdog_and_reset_status
  import watchdog_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic global_irq_enable,
  input wire logic irq_taken,
  input wire logic irq_return,
  input wire logic dog_restart_instruction,
  input wire logic slow_tick_pin,
  input wire logic use_fast_clock,
  input wire logic cause_power_on,
  input wire logic cause_pin,
  input wire logic cause_low_voltage,
  input wire logic cause_debugger,
  input wire logic cause_power_off_wake,
  output logic overflow_irq,
  output logic system_reset,
  output logic [15:0] reset_vector,
  output logic debug_port_off
);
  // ************************************************************
  // Bus slave
  // ************************************************************
  logic wr_pend_reg;
  logic [7:0] addr_pend_reg;
  wire take = hsel & hready & htrans[1];
  wire wr_cause = wr_pend_reg &&
    {24'h0, addr_pend_reg} == `OFS_RESET_CAUSE;
  wire wr_ctrl = wr_pend_reg &&
    {24'h0, addr_pend_reg} == `OFS_WDOG_CTRL;
  wire [7:0] wd = hwdata[7:0];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // Reads decode the full address and other reads see zero; writes decode only the low address byte.
  logic [7:0] ctrl_reg, cause_reg;
  wire [7:0] rd_next = (haddr[31:0] == `OFS_RESET_CAUSE) ? cause_reg :
    (haddr[31:0] == `OFS_WDOG_CTRL) ? ctrl_reg : 8'h00;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_reg <= 1'b0;
      addr_pend_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= take & hwrite;
      addr_pend_reg <= haddr[7:0];
      if (take & ~hwrite) begin
        hrdata <= {24'h000000, rd_next};
      end
    end
  end
  // ************************************************************
  // Watchdog clock
  // ************************************************************
  logic slow_s1_reg, slow_s2_reg, slow_s3_reg;
  logic [4:0] div_reg;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      slow_s1_reg <= 1'b0;
      slow_s2_reg <= 1'b0;
      slow_s3_reg <= 1'b0;
      div_reg <= 5'h00;
    end else begin
      slow_s1_reg <= slow_tick_pin;
      slow_s2_reg <= slow_s1_reg;
      slow_s3_reg <= slow_s2_reg;
      div_reg <= (div_reg == `FAST_DIV - 5'h01) ? 5'h00 : div_reg + 5'h01;
    end
  end
  // The slow oscillator arrives as a pin, so its edges are resynchronised.
  wire dog_tick = use_fast_clock ? (div_reg == 5'h00) : // R20
    (slow_s2_reg & ~slow_s3_reg);
  // ************************************************************
  // Counter and modes
  // ************************************************************
  function automatic logic [20:0] period_limit(input logic [3:0] code);
    logic [3:0] c;
    c = (code > `PERIOD_MAX_CODE) ? `PERIOD_MAX_CODE : code;
    period_limit = 21'h1 << (`PERIOD_BASE_LOG2 + {1'b0, c}); // R6
  endfunction
  logic [20:0] count_reg;
  logic [2:0] unlock_cnt_reg;
  logic [1:0] dbg_cnt_reg;
  logic convert_reg;
  wire [3:0] period_code = {ctrl_reg[`BIT_PER_MSB], ctrl_reg[2:0]}; // R5
  wire dog_mode_t mode = dog_mode_t'({ctrl_reg[`BIT_EN],
    ctrl_reg[`BIT_IRQ_EN]}); // R4
  wire running = mode != mode_stop;
  wire overflow = running && dog_tick && // R7
    (count_reg == period_limit(period_code) - 21'h1);
  wire reset_act = (mode == mode_reset) ||
    (mode == mode_irq_reset && convert_reg);
  wire irq_act = (mode == mode_irq) ||
    (mode == mode_irq_reset && !convert_reg);
  assign system_reset = overflow & reset_act; // R22
  assign reset_vector = `RESET_VECTOR; // R19
  assign overflow_irq = ctrl_reg[`BIT_IRQ_FLAG] && // R2
    ctrl_reg[`BIT_IRQ_EN] && global_irq_enable;
  assign debug_port_off = cause_reg[`BIT_DBG_DIS]; // R17
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= 21'h0;
    end else if (dog_restart_instruction || !running || overflow) begin
      count_reg <= 21'h0; // R21 R24
    end else if (dog_tick) begin
      count_reg <= count_reg + 21'h1;
    end
  end
  // ************************************************************
  // Control register
  // ************************************************************
  wire unlock_open = ctrl_reg[`BIT_UNLOCK];
  wire en_w = (wd[`BIT_EN] || (!unlock_open && ctrl_reg[`BIT_EN])) // R8
    || cause_reg[`BIT_DOGRST]; // R12
  logic [7:0] ctrl_next;
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next[6:0] = {wd[6:5], 1'b0, en_w, wd[2:0]};
      ctrl_next[`BIT_UNLOCK] = wd[`BIT_UNLOCK] & wd[`BIT_EN];
      if (wd[`BIT_IRQ_FLAG]) begin
        ctrl_next[`BIT_IRQ_FLAG] = 1'b0; // R3
      end
    end else if (unlock_cnt_reg == `UNLOCK_CYCLES - 3'h1) begin
      ctrl_next[`BIT_UNLOCK] = 1'b0; // R9
    end
    if (cause_reg[`BIT_DOGRST]) begin
      ctrl_next[`BIT_EN] = 1'b1; // R12
    end
    if (irq_taken) begin
      ctrl_next[`BIT_IRQ_FLAG] = 1'b0; // R3
    end
    // A fresh overflow wins over any clear in the same cycle.
    if (overflow && irq_act) begin
      ctrl_next[`BIT_IRQ_FLAG] = 1'b1; // R1
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= 8'h00;
      unlock_cnt_reg <= 3'h0;
      convert_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      unlock_cnt_reg <= ctrl_next[`BIT_UNLOCK] && !wr_ctrl ?
        unlock_cnt_reg + 3'h1 : 3'h0;
      if (mode != mode_irq_reset) begin
        convert_reg <= 1'b0;
      end else if (irq_return) begin
        convert_reg <= 1'b1; // R23
      end
    end
  end
  // ************************************************************
  // Reset cause register
  // ************************************************************
  // Flags survive the watchdog reset because this block itself only
  // sees the power-on reset.
  logic dbg_armed_reg;
  logic [7:0] cause_next;
  always_comb begin
    cause_next = cause_reg;
    if (wr_cause) begin
      cause_next[5:0] = cause_reg[5:0] & wd[5:0]; // R14 R15
      if (wd[`BIT_DBG_DIS] && dbg_armed_reg) begin
        cause_next[`BIT_DBG_DIS] = 1'b1; // R18
      end
    end
    if (cause_pin) cause_next[`BIT_PIN] = 1'b1; // R15
    if (cause_low_voltage) cause_next[`BIT_LVD] = 1'b1; // R15
    if (cause_debugger) cause_next[`BIT_DBG] = 1'b1; // R15
    if (cause_power_off_wake) cause_next[`BIT_PWROFF] = 1'b1; // R16
    if (system_reset && ctrl_reg[`BIT_EN]) begin
      cause_next[`BIT_DOGRST] = 1'b1; // R11
    end
    if (cause_power_on) begin
      cause_next = 8'h00; // R15
      cause_next[`BIT_POR] = 1'b1; // R14
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cause_reg <= 8'h00;
      dbg_armed_reg <= 1'b0;
      dbg_cnt_reg <= 2'h0;
    end else begin
      cause_reg <= cause_next;
      if (wr_cause && wd[`BIT_DBG_DIS] && !dbg_armed_reg) begin
        dbg_armed_reg <= 1'b1; // R18
        dbg_cnt_reg <= 2'h0;
      end else if (dbg_armed_reg) begin
        dbg_cnt_reg <= dbg_cnt_reg + 2'h1;
        if (dbg_cnt_reg == 2'h3 || wr_cause) begin
          dbg_armed_reg <= 1'b0;
        end
      end
    end
  end
endmodule // watchdog_and_reset_status
`default_nettype wire

// >>> dog_sva.sv
`default_nettype none
// ****************
// Port checker
// ****************
module dog_sva (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic global_irq_enable,
  input wire logic irq_taken,
  input wire logic dog_restart_instruction,
  input wire logic overflow_irq,
  input wire logic system_reset,
  input wire logic [15:0] reset_vector,
  input wire logic debug_port_off
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Cycles since the last reset pulse; it saturates so it never wraps.
  logic [11:0] gap_reg;
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n) gap_reg <= 12'h000;
    else if (system_reset) gap_reg <= 12'h000;
    else if (gap_reg != 12'hFFF) gap_reg <= gap_reg + 12'h001;
  irq_gate_a: assert property (overflow_irq |-> global_irq_enable)
    else $error("irq without global enable");
  taken_clear_a: assert property (irq_taken |=> !overflow_irq)
    else $error("irq stays after being taken");
  pulse_one_a: assert property (system_reset |=> !system_reset)
    else $error("reset pulse longer than one cycle");
  restart_hold_a: assert property ($rose(dog_restart_instruction)
    |=> !system_reset [*8]) else $error("reset right after restart");
  period_floor_a: assert property (system_reset |-> gap_reg >= 12'h7FF)
    else $error("overflow sooner than shortest period");
  vector_zero_a: assert property (reset_vector == 16'h0000)
    else $error("reset vector not zero");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  quiet_start_a: assert property ($rose(reset_n) |-> !debug_port_off
    && !overflow_irq && !system_reset) else $error("outputs set at start");
  cover property (system_reset);
  cover property (irq_taken);
  cover property ($rose(debug_port_off));
endmodule // dog_sva
bind watchdog_and_reset_status dog_sva chk_u (.ref_clk(ref_clk),
  .reset_n(reset_n), .hreadyout(hreadyout), .hresp(hresp),
  .global_irq_enable(global_irq_enable), .irq_taken(irq_taken),
  .dog_restart_instruction(dog_restart_instruction),
  .overflow_irq(overflow_irq), .system_reset(system_reset),
  .reset_vector(reset_vector), .debug_port_off(debug_port_off));
`default_nettype wire

// >>> core_model.sv
`default_nettype none
// ****************
// Core stand-in
// ****************
module core_model (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic overflow_irq,
  output logic irq_taken,
  output logic irq_return
);
  timeunit 1ns;
  timeprecision 100ps;
  // The service routine runs a few cycles, so a new request waits for it.
  logic [3:0] busy_reg;
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n) begin
      busy_reg <= 4'h0;
      irq_taken <= 1'h0;
      irq_return <= 1'h0;
    end else begin
      irq_taken <= overflow_irq && busy_reg == 4'h0 && !irq_taken;
      irq_return <= busy_reg == 4'h1;
      if (irq_taken) busy_reg <= 4'hA;
      else if (busy_reg != 4'h0) busy_reg <= busy_reg - 4'h1;
    end
endmodule // core_model
`default_nettype wire

// >>> test_watchdog_and_reset_status.sv
`default_nettype none
// ****************
// Bench
// ****************
module test_watchdog_and_reset_status;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'h0, reset_n = 1'h0, hwrite = 1'h0, glob = 1'h0;
  logic slow_tick = 1'h0, hready, hresp, irq, sysrst, dbg_off, taken, ret;
  logic [1:0] htrans = 2'h0;
  logic [5:0] kick = 6'h00;
  logic [15:0] vec;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdat;
  int n_errors = 0, n_tests = 0, cyc = 0, wait_n = 0;
  // The fast tick is used so an overflow fits in the run.
  watchdog_and_reset_status dut_u (.ref_clk(ref_clk), .reset_n(reset_n),
    .hsel(1'h1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .global_irq_enable(glob),
    .irq_taken(taken), .irq_return(ret), .dog_restart_instruction(kick[5]),
    .slow_tick_pin(slow_tick), .use_fast_clock(1'h1),
    .cause_power_on(kick[0]), .cause_pin(kick[1]),
    .cause_low_voltage(kick[2]), .cause_debugger(kick[3]),
    .cause_power_off_wake(kick[4]), .overflow_irq(irq),
    .system_reset(sysrst), .reset_vector(vec), .debug_port_off(dbg_off));
  core_model core_u (.ref_clk(ref_clk), .reset_n(reset_n),
    .overflow_irq(irq), .irq_taken(taken), .irq_return(ret));
  initial forever #12.5 ref_clk = ~ref_clk;
  always #512 slow_tick = ~slow_tick;
  task automatic results;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge ref_clk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'h1);
    rdat = hrdata;
  endtask
  task automatic rd(input logic [31:0] a, e);
    xfer(1'h0, a, 32'h0);
    chk("register", e, rdat);
  endtask
  task automatic pulse(input logic [5:0] k);
    kick <= k;
    @(posedge ref_clk);
    kick <= 6'h00;
    @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_errors++;
      results;
    end
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'h1;
    @(posedge ref_clk);
    rd(32'h60, 32'h00);
    pulse(6'h01);
    rd(32'h54, 32'h01);
    xfer(1'h1, 32'h54, 32'h00);
    rd(32'h54, 32'h00);
    pulse(6'h1E);
    rd(32'h54, 32'h36);
    pulse(6'h01);
    rd(32'h54, 32'h01);
    rd(32'h58, 32'h00);
    xfer(1'h1, 32'h60, 32'h27);
    rd(32'h60, 32'h27);
    xfer(1'h1, 32'h60, 32'h40);
    pulse(6'h20);
    repeat (32800) @(posedge ref_clk);
    rd(32'h60, 32'hC0);
    chk("irq", 32'h0, {31'h0, irq});
    glob <= 1'h1;
    repeat (8) @(posedge ref_clk);
    rd(32'h60, 32'h40);
    xfer(1'h1, 32'h60, 32'h08);
    pulse(6'h20);
    // Sampled on the falling edge, where the one-cycle pulse is settled.
    do begin
      @(negedge ref_clk);
      wait_n++;
    end while (sysrst !== 1'h1 && wait_n < 34000);
    @(posedge ref_clk);
    chk("period", 32'h1,
      {31'h0, wait_n > 32'h7FEE && wait_n < 32'h8016});
    rd(32'h54, 32'h09);
    xfer(1'h1, 32'h60, 32'h18);
    xfer(1'h1, 32'h60, 32'h00);
    repeat (6) @(posedge ref_clk);
    rd(32'h60, 32'h08);
    xfer(1'h1, 32'h54, 32'h00);
    xfer(1'h1, 32'h60, 32'h00);
    rd(32'h60, 32'h08);
    xfer(1'h1, 32'h60, 32'h18);
    repeat (6) @(posedge ref_clk);
    xfer(1'h1, 32'h60, 32'h00);
    rd(32'h60, 32'h08);
    xfer(1'h1, 32'h60, 32'h18);
    xfer(1'h1, 32'h60, 32'h00);
    repeat (6) @(posedge ref_clk);
    rd(32'h60, 32'h00);
    xfer(1'h1, 32'h54, 32'h80);
    repeat (8) @(posedge ref_clk);
    chk("debug off", 32'h0, {31'h0, dbg_off});
    xfer(1'h1, 32'h54, 32'h80);
    xfer(1'h1, 32'h54, 32'h80);
    repeat (2) @(posedge ref_clk);
    chk("debug off", 32'h1, {31'h0, dbg_off});
    results;
  end
endmodule // test_watchdog_and_reset_status
`default_nettype wire
